/* rtl/tio_status.sv */
// Purpose: T1 counter overflow, link event interrupts and overflow latch, read to clear
// Assumes: event inputs are one-cycle pulses or levels synchronous to clk
// Notes: masks arrive as inputs; a 1 in a mask bit means unmasked
`timescale 1ns/1ps
module tio_status
  import tio_pkg::*;
#(
  parameter int LOOP_CODE_CYCLES_P = LOOP_CODE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // parallel register port
  input wire tio_cpu_req_t cpu_req,
  output logic [7:0] cpu_rdata,
  output logic cpu_rdata_valid,
  // counter wrap pulses and mask
  input wire tio_counter_wrap_t counter_wrap,
  input wire logic [7:0] counter_irq_mask,
  // link event sources and mask
  input wire logic data_link_hdlc_event,
  input wire logic channel_hdlc_event,
  input wire logic loop_code_present,
  input wire logic one_second_status,
  input wire logic five_second_status,
  input wire logic [15:0] bom_word,
  input wire logic bom_word_valid,
  input wire logic [3:0] signaling_bits,
  input wire logic signaling_valid,
  input wire logic signaling_debounce_enable,
  input wire logic [7:0] event_irq_mask
);

  localparam logic [LOOP_CNT_W-1:0] LC_LAST = LOOP_CNT_W'(LOOP_CODE_CYCLES_P - 1);

  tio_cnt_ovf_irq_t counter_overflow_interrupts;
  tio_link_evt_irq_t link_event_interrupts;
  tio_ovf_latch_t overflow_report_latch;
  tio_cnt_ovf_irq_t next_counter_overflow_interrupts;
  tio_link_evt_irq_t next_link_event_interrupts;
  tio_ovf_latch_t next_overflow_report_latch;
  logic [7:0] next_cpu_rdata;
  logic next_cpu_rdata_valid;

  logic rd_cnt;
  logic rd_evt;
  logic rd_latch;
  logic [7:0] cnt_set;
  logic [7:0] evt_set;
  logic [7:0] latch_set;
  logic bom_new_msg;

  // edge and change detectors
  logic one_sec_prev;
  logic five_sec_prev;
  logic [3:0] sig_prev;
  logic [3:0] sig_accepted;
  logic next_one_sec_prev;
  logic next_five_sec_prev;
  logic [3:0] next_sig_prev;
  logic [3:0] next_sig_accepted;
  logic sig_change;

  // loop code timer
  tio_lc_state_t lc_state;
  tio_lc_state_t next_lc_state;
  logic [LOOP_CNT_W-1:0] lc_count;
  logic [LOOP_CNT_W-1:0] next_lc_count;
  logic lc_fire;

  assign rd_cnt = cpu_req.rd && cpu_req.addr == ADDR_CNT_OVF_IRQ;
  assign rd_evt = cpu_req.rd && cpu_req.addr == ADDR_LINK_EVT_IRQ;
  assign rd_latch = cpu_req.rd && cpu_req.addr == ADDR_OVF_LATCH;

  tio_bom_filter u_bom_filter (
    .clk(clk),
    .rst_n(rst_n),
    .bom_word(bom_word),
    .bom_word_valid(bom_word_valid),
    .bom_new_msg(bom_new_msg)
  );

  always_comb begin
    next_lc_state = lc_state;
    next_lc_count = lc_count;
    lc_fire = 1'b0;
    case (lc_state)
      LC_IDLE: begin
        next_lc_count = '0;
        if (loop_code_present) begin
          next_lc_state = LC_COUNT;
        end
      end
      LC_COUNT: begin
        if (!loop_code_present) begin
          next_lc_state = LC_IDLE;
        end else if (lc_count == LC_LAST) begin
          lc_fire = 1'b1;
          next_lc_state = LC_HELD;
        end else begin
          next_lc_count = lc_count + 1'b1;
        end
      end
      LC_HELD: begin
        // one report per continuous detection
        if (!loop_code_present) begin
          next_lc_state = LC_IDLE;
        end
      end
      default: begin
        next_lc_state = LC_IDLE;
      end
    endcase
  end

  always_comb begin
    next_one_sec_prev = one_second_status;
    next_five_sec_prev = five_second_status;
    next_sig_prev = sig_prev;
    next_sig_accepted = sig_accepted;
    sig_change = 1'b0;
    if (signaling_valid) begin
      next_sig_prev = signaling_bits;
      // debounce asks for two equal samples in a row
      if (signaling_bits != sig_accepted &&
          (!signaling_debounce_enable || signaling_bits == sig_prev)) begin
        next_sig_accepted = signaling_bits;
        sig_change = 1'b1;
      end
    end
  end

  always_comb begin
    cnt_set = counter_wrap & counter_irq_mask;
    latch_set = counter_wrap;
    evt_set = 8'h00;
    evt_set[6] = data_link_hdlc_event;
    evt_set[5] = channel_hdlc_event;
    evt_set[4] = lc_fire;
    evt_set[3] = one_second_status && !one_sec_prev;
    evt_set[2] = five_second_status && !five_sec_prev;
    evt_set[1] = bom_new_msg;
    evt_set[0] = sig_change;
    evt_set = evt_set & event_irq_mask & 8'h7F;
  end

  always_comb begin
    next_cpu_rdata_valid = cpu_req.rd;
    next_cpu_rdata = cpu_rdata;
    if (rd_cnt) begin
      next_cpu_rdata = counter_overflow_interrupts;
    end else if (rd_evt) begin
      next_cpu_rdata = link_event_interrupts;
    end else if (rd_latch) begin
      next_cpu_rdata = overflow_report_latch;
    end else if (cpu_req.rd) begin
      next_cpu_rdata = UNMAPPED_READ;
    end
    next_counter_overflow_interrupts = (rd_cnt ? 8'h00 : counter_overflow_interrupts) | cnt_set;
    next_link_event_interrupts = (rd_evt ? 8'h00 : link_event_interrupts) | evt_set;
    next_overflow_report_latch = (rd_latch ? 8'h00 : overflow_report_latch) | latch_set;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      counter_overflow_interrupts <= WORD_RESET;
      link_event_interrupts <= WORD_RESET;
      overflow_report_latch <= WORD_RESET;
      cpu_rdata <= WORD_RESET;
      cpu_rdata_valid <= 1'b0;
      one_sec_prev <= 1'b0;
      five_sec_prev <= 1'b0;
      sig_prev <= 4'h0;
      sig_accepted <= 4'h0;
      lc_state <= LC_IDLE;
      lc_count <= '0;
    end else begin
      counter_overflow_interrupts <= next_counter_overflow_interrupts;
      link_event_interrupts <= next_link_event_interrupts;
      overflow_report_latch <= next_overflow_report_latch;
      cpu_rdata <= next_cpu_rdata;
      cpu_rdata_valid <= next_cpu_rdata_valid;
      one_sec_prev <= next_one_sec_prev;
      five_sec_prev <= next_five_sec_prev;
      sig_prev <= next_sig_prev;
      sig_accepted <= next_sig_accepted;
      lc_state <= next_lc_state;
      lc_count <= next_lc_count;
    end
  end

  sequence s_cnt_read;
    rd_cnt;
  endsequence

  sequence s_cnt_quiet;
    cnt_set == 8'h00;
  endsequence

  sequence s_cnt_busy;
    cnt_set != 8'h00;
  endsequence

  for (genvar i = 0; i < 8; i++) begin : g_cnt_chk
    property p_cnt_set;
      @(posedge clk) disable iff (!rst_n)
        counter_wrap[i] && counter_irq_mask[i] |=> counter_overflow_interrupts[i];
    endproperty
    a_cnt_set: assert property (p_cnt_set)
      else $error("unmasked counter wrap did not set its bit");
  end

  property p_mask_hold;
    @(posedge clk) disable iff (!rst_n)
      s_cnt_quiet and (!rd_cnt && (counter_wrap & ~counter_irq_mask) != 8'h00)
        |=> $stable(counter_overflow_interrupts);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("masked wrap changed the overflow word");

  property p_read_clear;
    @(posedge clk) disable iff (!rst_n)
      s_cnt_read and s_cnt_quiet |=> counter_overflow_interrupts == 8'h00 &&
        cpu_rdata == $past(counter_overflow_interrupts) && cpu_rdata_valid;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("read did not return and clear the overflow word");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
      s_cnt_read and s_cnt_busy |=> counter_overflow_interrupts == $past(cnt_set);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost in clearing read cycle");

  property p_latch_hold;
    @(posedge clk) disable iff (!rst_n)
      !rd_latch |=> (overflow_report_latch & $past(overflow_report_latch)) ==
        $past(overflow_report_latch) &&
        (overflow_report_latch & $past(counter_wrap)) == $past(counter_wrap);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch bit lost or overflow not latched");

  property p_latch_read;
    @(posedge clk) disable iff (!rst_n)
      rd_latch && counter_wrap == 8'h00 |=> overflow_report_latch == 8'h00 &&
        cpu_rdata_valid && cpu_rdata == $past(overflow_report_latch);
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("latch not cleared by its read");

  property p_unused_zero;
    @(posedge clk) disable iff (!rst_n)
      link_event_interrupts.unused == 1'b0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused event bit set");

  property p_one_sec;
    @(posedge clk) disable iff (!rst_n)
      $rose(one_second_status) && event_irq_mask[3] |=> link_event_interrupts.one_second_irq;
  endproperty
  a_one_sec: assert property (p_one_sec)
    else $error("one second rise not reported");

  property p_loop_fire;
    @(posedge clk) disable iff (!rst_n)
      lc_fire |-> lc_count == LC_LAST && loop_code_present && $past(loop_code_present);
  endproperty
  a_loop_fire: assert property (p_loop_fire)
    else $error("loop code reported before full persistence");

  property p_sig_change;
    @(posedge clk) disable iff (!rst_n)
      signaling_valid && !signaling_debounce_enable && signaling_bits != sig_accepted &&
        event_irq_mask[0] |=> link_event_interrupts.signaling_change_irq;
  endproperty
  a_sig_change: assert property (p_sig_change)
    else $error("signaling change not reported");

endmodule : tio_status

/* rtl/tio_pkg.sv */
// Purpose: shared constants and carriers for the T1 interrupt and overflow status block
// Assumes: framer system clock of 25 MHz, parallel port reads of one cycle
// Notes: field order in the structs is the bit order of the status words, msb first
package tio_pkg;

  // register offsets on the parallel port
  localparam logic [4:0] ADDR_CNT_OVF_IRQ = 5'h1D;
  localparam logic [4:0] ADDR_LINK_EVT_IRQ = 5'h1E;
  localparam logic [4:0] ADDR_OVF_LATCH = 5'h1F;

  // reset and read values
  localparam logic [7:0] WORD_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // loop code persistence time
  localparam int CLK_HZ = 25000000;
  localparam int LOOP_CODE_MS = 48;
  localparam int LOOP_CODE_CYCLES = LOOP_CODE_MS * (CLK_HZ / 1000);
  localparam int LOOP_CNT_W = 21;

  // bit-oriented message filter
  localparam logic [15:0] BOM_CARE = 16'hFF81;
  localparam logic [15:0] BOM_MATCH = 16'hFF00;
  localparam logic [15:0] BOM_RESET = 16'h0000;
  localparam int BOM_WINDOW = 10;
  localparam logic [3:0] BOM_MIN_HITS = 4'h8;

  // counter wrap pulses, also the layout of the overflow words
  typedef struct packed {
    logic fbit_err;
    logic crc6_err;
    logic out_of_frame;
    logic align_change;
    logic bipolar_viol;
    logic prbs_err;
    logic prbs_multiframe;
    logic multiframe_sync_loss;
  } tio_counter_wrap_t;

  typedef struct packed {
    logic fbit_err_ovf_irq;
    logic crc6_err_ovf_irq;
    logic out_of_frame_ovf_irq;
    logic align_change_ovf_irq;
    logic bipolar_viol_ovf_irq;
    logic prbs_err_ovf_irq;
    logic prbs_multiframe_ovf_irq;
    logic multiframe_sync_loss_ovf_irq;
  } tio_cnt_ovf_irq_t;

  typedef struct packed {
    logic fbit_err_ovf_latch;
    logic crc6_err_ovf_latch;
    logic out_of_frame_ovf_latch;
    logic align_change_ovf_latch;
    logic bipolar_viol_ovf_latch;
    logic prbs_err_ovf_latch;
    logic prbs_multiframe_ovf_latch;
    logic multiframe_sync_loss_ovf_latch;
  } tio_ovf_latch_t;

  typedef struct packed {
    logic unused;
    logic data_link_hdlc_irq;
    logic channel_hdlc_irq;
    logic loop_code_irq;
    logic one_second_irq;
    logic five_second_irq;
    logic bit_message_irq;
    logic signaling_change_irq;
  } tio_link_evt_irq_t;

  // processor read request
  typedef struct packed {
    logic rd;
    logic [4:0] addr;
  } tio_cpu_req_t;

  // loop code timer states
  typedef enum logic [2:0] {
    LC_IDLE = 3'b001,
    LC_COUNT = 3'b010,
    LC_HELD = 3'b100
  } tio_lc_state_t;

endpackage : tio_pkg

/* rtl/tio_bom_filter.sv */
// Purpose: qualify bit-oriented messages on the facility data link
// Assumes: one bom_word_valid pulse per received message position
// Notes: a different candidate restarts the window; interleaved messages delay acceptance
`timescale 1ns/1ps
module tio_bom_filter
  import tio_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // message positions
  input wire logic [15:0] bom_word,
  input wire logic bom_word_valid,
  // accepted new message
  output logic bom_new_msg
);

  logic [15:0] candidate;
  logic [15:0] accepted;
  logic [BOM_WINDOW-1:0] hits;
  logic [15:0] next_candidate;
  logic [15:0] next_accepted;
  logic [BOM_WINDOW-1:0] next_hits;
  logic next_bom_new_msg;
  logic word_ok;

  function automatic logic [3:0] count_hits(input logic [BOM_WINDOW-1:0] h);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < BOM_WINDOW; i++) begin
      n = n + {3'h0, h[i]};
    end
    return n;
  endfunction : count_hits

  assign word_ok = (bom_word & BOM_CARE) == BOM_MATCH;

  always_comb begin
    next_candidate = candidate;
    next_accepted = accepted;
    next_hits = hits;
    next_bom_new_msg = 1'b0;
    if (bom_word_valid) begin
      if (word_ok && bom_word == candidate) begin
        next_hits = {hits[BOM_WINDOW-2:0], 1'b1};
      end else if (word_ok) begin
        next_candidate = bom_word;
        next_hits = {{(BOM_WINDOW-1){1'b0}}, 1'b1};
      end else begin
        next_hits = {hits[BOM_WINDOW-2:0], 1'b0};
      end
      if (count_hits(next_hits) >= BOM_MIN_HITS && next_candidate != accepted) begin
        next_accepted = next_candidate;
        next_bom_new_msg = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      candidate <= BOM_RESET;
      accepted <= BOM_RESET;
      hits <= '0;
      bom_new_msg <= 1'b0;
    end else begin
      candidate <= next_candidate;
      accepted <= next_accepted;
      hits <= next_hits;
      bom_new_msg <= next_bom_new_msg;
    end
  end

  property p_bom_accept;
    @(posedge clk) disable iff (!rst_n)
      bom_new_msg |-> count_hits(hits) >= BOM_MIN_HITS && $past(bom_word_valid);
  endproperty
  a_bom_accept: assert property (p_bom_accept)
    else $error("message accepted without eight hits");

endmodule : tio_bom_filter

/* verif/tio_cpu_model.sv */
// Purpose: processor model reading the status words over the parallel port
// Assumes: one-cycle read strobe; answer within three cycles of the strobe
// Notes: address is inverted once released so no read relies on a stale value
`timescale 1ns/1ps
module tio_cpu_model
  import tio_pkg::*;
(
  // clock
  input wire logic clk,
  // parallel register port
  output tio_cpu_req_t cpu_req,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_rdata_valid
);
  initial begin
    cpu_req = '{rd: 1'b0, addr: 5'h00};
  end

  // returns all x when no answer comes, so the caller always sees a mismatch
  task automatic read_word(input logic [4:0] addr, output logic [7:0] data);
    int n;
    data = 8'hXX;
    @(negedge clk);
    cpu_req.rd = 1'b1;
    cpu_req.addr = addr;
    @(negedge clk);
    cpu_req.rd = 1'b0;
    cpu_req.addr = ~addr;
    for (n = 0; n < 3; n++) begin
      if (cpu_rdata_valid === 1'b1) begin
        data = cpu_rdata;
        break;
      end
      @(negedge clk);
    end
  endtask : read_word
endmodule : tio_cpu_model

/* verif/tio_status_test.sv */
// Purpose: self-checking bench for the T1 interrupt and overflow status block
// Assumes: inputs change on the falling edge; reads go through the processor model
// Notes: loop code time cut to 20 cycles to keep the run short
`timescale 1ns/1ps
module tio_status_test
  import tio_pkg::*;
;
  localparam int LC_P = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  tio_cpu_req_t cpu_req;
  logic [7:0] cpu_rdata;
  logic cpu_rdata_valid;
  tio_counter_wrap_t counter_wrap = '0;
  logic [7:0] counter_irq_mask = 8'hFF;
  logic [7:0] event_irq_mask = 8'hFF;
  logic data_link_hdlc_event = 1'b0;
  logic channel_hdlc_event = 1'b0;
  logic loop_code_present = 1'b0;
  logic one_second_status = 1'b0;
  logic five_second_status = 1'b0;
  logic [15:0] bom_word = 16'h0000;
  logic bom_word_valid = 1'b0;
  logic [3:0] signaling_bits = 4'h0;
  logic signaling_valid = 1'b0;
  logic signaling_debounce_enable = 1'b0;
  int failures = 0;
  int compares = 0;

  always #20 clk = ~clk;

  tio_status #(.LOOP_CODE_CYCLES_P(LC_P)) u_tio_status (
    .clk(clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .cpu_rdata_valid(cpu_rdata_valid), .counter_wrap(counter_wrap),
    .counter_irq_mask(counter_irq_mask), .data_link_hdlc_event(data_link_hdlc_event),
    .channel_hdlc_event(channel_hdlc_event), .loop_code_present(loop_code_present),
    .one_second_status(one_second_status), .five_second_status(five_second_status),
    .bom_word(bom_word), .bom_word_valid(bom_word_valid), .signaling_bits(signaling_bits),
    .signaling_valid(signaling_valid),
    .signaling_debounce_enable(signaling_debounce_enable), .event_irq_mask(event_irq_mask)
  );

  tio_cpu_model u_tio_cpu_model (
    .clk(clk), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .cpu_rdata_valid(cpu_rdata_valid)
  );

  task automatic give_verdict;
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // two idle cycles first so every event before the call has landed
  task automatic read_check(input logic [4:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    repeat (2) @(negedge clk);
    u_tio_cpu_model.read_word(addr, got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t: addr %h got %h exp %h", $time, addr, got, exp);
    end
  endtask : read_check

  task automatic pulse_wrap(input logic [7:0] v);
    @(negedge clk);
    counter_wrap = v;
    @(negedge clk);
    counter_wrap = '0;
  endtask : pulse_wrap

  // released lines show the inverse so the design cannot lean on them
  task automatic send_bom(input logic [15:0] w);
    @(negedge clk);
    bom_word = w;
    bom_word_valid = 1'b1;
    @(negedge clk);
    bom_word = ~w;
    bom_word_valid = 1'b0;
  endtask : send_bom

  task automatic send_sig(input logic [3:0] v);
    @(negedge clk);
    signaling_bits = v;
    signaling_valid = 1'b1;
    @(negedge clk);
    signaling_bits = ~v;
    signaling_valid = 1'b0;
  endtask : send_sig

  initial begin
    #(40 * 20000);
    failures++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    read_check(ADDR_CNT_OVF_IRQ, WORD_RESET);
    read_check(ADDR_LINK_EVT_IRQ, WORD_RESET);
    read_check(ADDR_OVF_LATCH, WORD_RESET);
    // each wrap to its own bit
    for (int i = 0; i < 8; i++) begin
      pulse_wrap(8'h01 << i);
      read_check(ADDR_CNT_OVF_IRQ, 8'h01 << i);
      read_check(ADDR_CNT_OVF_IRQ, 8'h00);
      read_check(5'h1C, UNMAPPED_READ);
      read_check(ADDR_OVF_LATCH, 8'h01 << i);
      read_check(ADDR_OVF_LATCH, 8'h00);
    end
    // masked wraps ignored, latch still set
    counter_irq_mask = 8'h5A;
    pulse_wrap(8'hFF);
    read_check(ADDR_CNT_OVF_IRQ, 8'h5A);
    read_check(ADDR_OVF_LATCH, 8'hFF);
    // fully masked wraps leave the word alone
    counter_irq_mask = 8'h00;
    pulse_wrap(8'h81);
    read_check(ADDR_CNT_OVF_IRQ, 8'h00);
    read_check(ADDR_OVF_LATCH, 8'h81);
    counter_irq_mask = 8'hFF;
    // event in the clearing read cycle survives
    pulse_wrap(8'h08);
    fork
      read_check(ADDR_CNT_OVF_IRQ, 8'h08);
      begin
        repeat (2) @(negedge clk);
        pulse_wrap(8'h08);
      end
    join
    read_check(ADDR_CNT_OVF_IRQ, 8'h08);
    read_check(ADDR_CNT_OVF_IRQ, 8'h00);
    read_check(ADDR_OVF_LATCH, 8'h08);
    // event word sources, bit 7 stays low
    @(negedge clk);
    data_link_hdlc_event = 1'b1;
    channel_hdlc_event = 1'b1;
    one_second_status = 1'b1;
    five_second_status = 1'b1;
    @(negedge clk);
    data_link_hdlc_event = 1'b0;
    channel_hdlc_event = 1'b0;
    read_check(ADDR_LINK_EVT_IRQ, 8'h6C);
    read_check(ADDR_LINK_EVT_IRQ, 8'h00);
    one_second_status = 1'b0;
    five_second_status = 1'b0;
    event_irq_mask = 8'hF7;
    @(negedge clk);
    one_second_status = 1'b1;
    five_second_status = 1'b1;
    read_check(ADDR_LINK_EVT_IRQ, 8'h04);
    one_second_status = 1'b0;
    five_second_status = 1'b0;
    event_irq_mask = 8'hFF;
    // loop code must persist, fires once
    loop_code_present = 1'b1;
    repeat (8) @(negedge clk);
    read_check(ADDR_LINK_EVT_IRQ, 8'h00);
    repeat (15) @(negedge clk);
    read_check(ADDR_LINK_EVT_IRQ, 8'h10);
    repeat (30) @(negedge clk);
    read_check(ADDR_LINK_EVT_IRQ, 8'h00);
    loop_code_present = 1'b0;
    repeat (10) @(negedge clk);
    loop_code_present = 1'b1;
    repeat (10) @(negedge clk);
    loop_code_present = 1'b0;
    @(negedge clk);
    loop_code_present = 1'b1;
    // total presence passes the limit only if the drop failed to restart the timer
    repeat (8) @(negedge clk);
    read_check(ADDR_LINK_EVT_IRQ, 8'h00);
    loop_code_present = 1'b0;
    // eight of ten positions, new message only
    for (int i = 0; i < 7; i++) begin
      send_bom(16'hFF02);
    end
    read_check(ADDR_LINK_EVT_IRQ, 8'h00);
    send_bom(16'hFF02);
    read_check(ADDR_LINK_EVT_IRQ, 8'h02);
    for (int i = 0; i < 10; i++) begin
      send_bom(16'hFF02);
    end
    read_check(ADDR_LINK_EVT_IRQ, 8'h00);
    for (int i = 0; i < 6; i++) begin
      send_bom(16'hFF04);
    end
    send_bom(16'h1234);
    send_bom(16'hFF04);
    read_check(ADDR_LINK_EVT_IRQ, 8'h00);
    send_bom(16'hFF04);
    read_check(ADDR_LINK_EVT_IRQ, 8'h02);
    send_sig(4'h5);
    read_check(ADDR_LINK_EVT_IRQ, 8'h01);
    send_sig(4'h5);
    read_check(ADDR_LINK_EVT_IRQ, 8'h00);
    signaling_debounce_enable = 1'b1;
    send_sig(4'hA);
    read_check(ADDR_LINK_EVT_IRQ, 8'h00);
    send_sig(4'hA);
    read_check(ADDR_LINK_EVT_IRQ, 8'h01);
    give_verdict();
  end
endmodule : tio_status_test
